/* File: hdl/dct_pkg.sv */
// Constants, register map and field layout of the diagnostic threshold register bank
package dct_pkg;

	// ****************************************************************
	// Register indices and APB byte addresses (index times four)
	// ****************************************************************
	localparam int DCT_ADDR_W = 12;
	localparam logic [11:0] DCT_IDX_BAL_HI = 12'h338;
	localparam logic [11:0] DCT_IDX_BAL_LO = 12'h339;
	localparam logic [11:0] DCT_IDX_CELL_THR = 12'h33A;
	localparam logic [11:0] DCT_IDX_PIN_OPEN_WIRE_LIMIT = 12'h33B;
	localparam logic [11:0] DCT_ADDR_BAL_HI = {DCT_IDX_BAL_HI[9:0], 2'b00};
	localparam logic [11:0] DCT_ADDR_BAL_LO = {DCT_IDX_BAL_LO[9:0], 2'b00};
	localparam logic [11:0] DCT_ADDR_CELL_THR = {DCT_IDX_CELL_THR[9:0], 2'b00};
	localparam logic [11:0] DCT_ADDR_PIN_OPEN_WIRE_LIMIT = {DCT_IDX_PIN_OPEN_WIRE_LIMIT[9:0], 2'b00};

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] DCT_RST_BYTE = 8'h00;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int DCT_CELL_LIM_LSB = 0;
	localparam int DCT_CELL_LIM_MSB = 4;
	localparam int DCT_BB_MARGIN_LSB = 5;
	localparam int DCT_BB_MARGIN_MSB = 7;
	localparam int DCT_OW_LIM_LSB = 0;
	localparam int DCT_OW_LIM_MSB = 3;
	localparam int DCT_PIN_LIM_LSB = 4;
	localparam int DCT_PIN_LIM_MSB = 6;
	localparam int DCT_PIN_OW_RSVD = 7;

	// ****************************************************************
	// Comparator selection code and threshold scaling in mV
	// ****************************************************************
	localparam logic [2:0] DCT_SEL_BAL_SWITCH = 3'h4;
	localparam logic [7:0] DCT_CELL_MIN_MV = 8'h06;
	localparam logic [7:0] DCT_CELL_STEP_MV = 8'h03;
	localparam logic [7:0] DCT_BB_MIN_MV = 8'h05;
	localparam logic [7:0] DCT_BB_STEP_MV = 8'h05;
	localparam logic [5:0] DCT_PIN_MIN_MV = 6'h04;
	localparam logic [5:0] DCT_PIN_STEP_MV = 6'h04;
	localparam logic [12:0] DCT_OW_MIN_MV = 13'h01F4;
	localparam logic [12:0] DCT_OW_STEP_MV = 13'h012C;

	// APB access phase state
	typedef enum logic [0:0] {DCT_ST_IDLE, DCT_ST_DONE} dct_apb_st_t;

endpackage

/* File: hdl/dct_regs.sv */
// APB register bank holding balancing-switch diagnostic enables and comparison thresholds
`timescale 1ns/1ps
module dct_regs
	import dct_pkg::*;
#(
	parameter bit BB_MARGIN_IMPL = 1'b1
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Comparator selection from the neighbouring control register
	input wire logic [2:0] comp_sel,
	// Balancing switch drive during diagnostic, bit 15 is channel 16
	output logic [15:0] balancing_switch_on,
	// Cell comparison request
	input wire logic cell_cmp_valid,
	input wire logic [15:0] main_cell_reading,
	input wire logic [15:0] aux_cell_reading,
	input wire logic cell_above_busbar,
	output logic cell_cmp_done,
	output logic cell_cmp_pass,
	// Pin comparison request
	input wire logic pin_cmp_valid,
	input wire logic [15:0] main_pin_reading,
	input wire logic [15:0] aux_pin_reading,
	output logic pin_cmp_done,
	output logic pin_cmp_pass,
	// Decoded limits in mV
	output logic [7:0] cell_delta_limit_mv,
	output logic [7:0] busbar_margin_mv,
	output logic [5:0] aux_pin_delta_limit_mv,
	output logic [12:0] open_wire_limit_cell_balance_pin_mv,
	output logic [12:0] open_wire_limit_cell_sense_pin_mv
);

	// ****************************************************************
	// Address decode
	// ****************************************************************

	// One-hot register select; all zero for an unmapped address
	function automatic logic [3:0] dct_hit(input logic [11:0] addr);
		dct_hit = {addr == DCT_ADDR_PIN_OPEN_WIRE_LIMIT, addr == DCT_ADDR_CELL_THR,
			addr == DCT_ADDR_BAL_LO, addr == DCT_ADDR_BAL_HI};
	endfunction

	// Absolute difference of two readings
	function automatic logic [15:0] dct_absdiff(input logic [15:0] a, input logic [15:0] b);
		dct_absdiff = (a >= b) ? (a - b) : (b - a);
	endfunction

	// ****************************************************************
	// Storage
	// ****************************************************************
	logic [7:0] bal_hi_reg;
	logic [7:0] bal_lo_reg;
	logic [7:0] cell_thr_reg;
	logic [7:0] pin_open_wire_limit_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	dct_apb_st_t apb_st_reg;
	logic [3:0] hit;
	logic wr_fire;
	logic [7:0] rd_byte;
	logic [4:0] cell_code;
	logic [2:0] margin_code;
	logic [2:0] pin_code;
	logic [3:0] ow_code;
	logic [7:0] margin_eff;
	logic [7:0] cell_limit_eff;
	logic [15:0] cell_diff;
	logic [15:0] pin_diff;

	assign hit = dct_hit(paddr);
	// Write commits only on the completing edge of the access phase
	assign wr_fire = psel && penable && pready && pwrite && pstrb[0] && (hit != 4'h0);

	// ****************************************************************
	// APB handshake
	// ****************************************************************

	// One wait state so read data can come from a flop; pready pulses one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_st_reg <= DCT_ST_IDLE;
		end else begin
			case (apb_st_reg)
				DCT_ST_IDLE: begin
					if (psel && penable) begin
						apb_st_reg <= DCT_ST_DONE;
					end
				end
				DCT_ST_DONE: apb_st_reg <= DCT_ST_IDLE;
				default: apb_st_reg <= DCT_ST_IDLE;
			endcase
		end
	end

	assign pready = (apb_st_reg == DCT_ST_DONE);

	// Read mux; reserved bit of the pin/open-wire register reads zero
	always_comb begin
		rd_byte = DCT_RST_BYTE;
		case (1'b1)
			hit[0]: rd_byte = bal_hi_reg;
			hit[1]: rd_byte = bal_lo_reg;
			hit[2]: rd_byte = BB_MARGIN_IMPL ? cell_thr_reg : {3'h0, cell_thr_reg[4:0]};
			hit[3]: rd_byte = {1'b0, pin_open_wire_limit_reg[6:0]};
			default: rd_byte = DCT_RST_BYTE;
		endcase
	end

	// Read data and error captured in the wait state, held through pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else if (psel && penable && (apb_st_reg == DCT_ST_IDLE)) begin
			prdata_reg <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
			pslverr_reg <= (hit == 4'h0);
		end
	end

	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg && pready;

	// ****************************************************************
	// Register writes
	// ****************************************************************

	// Byte lane 0 carries the register; other lanes are ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bal_hi_reg <= DCT_RST_BYTE;
			bal_lo_reg <= DCT_RST_BYTE;
			cell_thr_reg <= DCT_RST_BYTE;
			pin_open_wire_limit_reg <= DCT_RST_BYTE;
		end else if (wr_fire) begin
			if (hit[0]) bal_hi_reg <= pwdata[7:0];
			if (hit[1]) bal_lo_reg <= pwdata[7:0];
			if (hit[2]) cell_thr_reg <= pwdata[7:0];
			if (hit[3]) pin_open_wire_limit_reg <= {1'b0, pwdata[6:0]};
		end
	end

	// ****************************************************************
	// Balancing switch diagnostic drive
	// ****************************************************************

	// Enables are ignored unless the switch diagnostic is selected
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			balancing_switch_on <= 16'h0000;
		end else if (comp_sel == DCT_SEL_BAL_SWITCH) begin
			balancing_switch_on <= {bal_hi_reg, bal_lo_reg};
		end else begin
			balancing_switch_on <= 16'h0000;
		end
	end

	// ****************************************************************
	// Threshold decode
	// ****************************************************************
	assign cell_code = cell_thr_reg[DCT_CELL_LIM_MSB:DCT_CELL_LIM_LSB];
	assign margin_code = cell_thr_reg[DCT_BB_MARGIN_MSB:DCT_BB_MARGIN_LSB];
	assign pin_code = pin_open_wire_limit_reg[DCT_PIN_LIM_MSB:DCT_PIN_LIM_LSB];
	assign ow_code = pin_open_wire_limit_reg[DCT_OW_LIM_MSB:DCT_OW_LIM_LSB];

	// Linear decode, minimum plus code times step, registered for timing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cell_delta_limit_mv <= DCT_CELL_MIN_MV;
			busbar_margin_mv <= DCT_BB_MIN_MV;
			aux_pin_delta_limit_mv <= DCT_PIN_MIN_MV;
			open_wire_limit_cell_balance_pin_mv <= DCT_OW_MIN_MV;
			open_wire_limit_cell_sense_pin_mv <= DCT_OW_MIN_MV;
		end else begin
			cell_delta_limit_mv <= DCT_CELL_MIN_MV + {3'h0, cell_code} * DCT_CELL_STEP_MV;
			busbar_margin_mv <= DCT_BB_MIN_MV + {5'h00, margin_code} * DCT_BB_STEP_MV;
			aux_pin_delta_limit_mv <= DCT_PIN_MIN_MV + {3'h0, pin_code} * DCT_PIN_STEP_MV;
			// Same limit feeds both open-wire checks
			open_wire_limit_cell_balance_pin_mv <=
				DCT_OW_MIN_MV + {9'h000, ow_code} * DCT_OW_STEP_MV;
			open_wire_limit_cell_sense_pin_mv <=
				DCT_OW_MIN_MV + {9'h000, ow_code} * DCT_OW_STEP_MV;
		end
	end

	// ****************************************************************
	// Main versus auxiliary comparisons
	// ****************************************************************

	// Margin only for a cell above an individually wired bus bar
	assign margin_eff = (BB_MARGIN_IMPL && cell_above_busbar) ? busbar_margin_mv : 8'h00;
	// Bus-bar channels are issued with the flag low, so they see the plain cell limit
	assign cell_limit_eff = cell_delta_limit_mv + margin_eff;
	assign cell_diff = dct_absdiff(main_cell_reading, aux_cell_reading);
	assign pin_diff = dct_absdiff(main_pin_reading, aux_pin_reading);

	// Pass is strict: a difference equal to the limit fails
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cell_cmp_done <= 1'b0;
			cell_cmp_pass <= 1'b0;
		end else begin
			cell_cmp_done <= cell_cmp_valid;
			if (cell_cmp_valid) begin
				cell_cmp_pass <= cell_diff < {8'h00, cell_limit_eff};
			end
		end
	end

	// Pin comparison against its own limit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_cmp_done <= 1'b0;
			pin_cmp_pass <= 1'b0;
		end else begin
			pin_cmp_done <= pin_cmp_valid;
			if (pin_cmp_valid) begin
				pin_cmp_pass <= pin_diff < {10'h000, aux_pin_delta_limit_mv};
			end
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************

	// Setup then first access cycle of an APB transfer
	sequence seq_apb_setup;
		psel && !penable;
	endsequence

	sequence seq_apb_first_access;
		psel && penable && !pready;
	endsequence

	a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
		seq_apb_setup ##1 seq_apb_first_access |=> pready ##1 !pready)
		else $error("pready not exactly one wait state");

	a_bal_gate_sel: assert property (@(posedge pclk) disable iff (!presetn)
		comp_sel != DCT_SEL_BAL_SWITCH |=> balancing_switch_on == 16'h0000)
		else $error("switch drive active outside switch diagnostic");

	a_bal_map_channels: assert property (@(posedge pclk) disable iff (!presetn)
		comp_sel == DCT_SEL_BAL_SWITCH |=>
		balancing_switch_on == {$past(bal_hi_reg), $past(bal_lo_reg)})
		else $error("switch drive does not follow enable registers");

	a_cell_pass_strict: assert property (@(posedge pclk) disable iff (!presetn)
		cell_cmp_valid |=> cell_cmp_done &&
		(cell_cmp_pass == ($past(cell_diff) < {8'h00, $past(cell_limit_eff)})))
		else $error("cell check result wrong");

	a_cell_limit_map: assert property (@(posedge pclk) disable iff (!presetn)
		##1 cell_delta_limit_mv == 8'(DCT_CELL_MIN_MV + $past(cell_code) * DCT_CELL_STEP_MV))
		else $error("cell limit decode wrong");

	a_busbar_same_limit: assert property (@(posedge pclk) disable iff (!presetn)
		cell_cmp_valid && !cell_above_busbar && cell_diff == {8'h00, cell_delta_limit_mv}
		|=> !cell_cmp_pass)
		else $error("bus-bar check not using plain cell limit");

	a_margin_added: assert property (@(posedge pclk) disable iff (!presetn)
		cell_cmp_valid && cell_above_busbar && BB_MARGIN_IMPL &&
		cell_diff == {8'h00, cell_delta_limit_mv} |=> cell_cmp_pass)
		else $error("bus-bar margin not added");

	a_pin_limit_map: assert property (@(posedge pclk) disable iff (!presetn)
		##1 aux_pin_delta_limit_mv == 6'(DCT_PIN_MIN_MV + $past(pin_code) * DCT_PIN_STEP_MV))
		else $error("pin limit decode wrong");

	a_ow_limit_map: assert property (@(posedge pclk) disable iff (!presetn)
		##1 open_wire_limit_cell_sense_pin_mv ==
		13'(DCT_OW_MIN_MV + $past(ow_code) * DCT_OW_STEP_MV))
		else $error("open-wire limit decode wrong");

	a_ow_both_pins: assert property (@(posedge pclk) disable iff (!presetn)
		open_wire_limit_cell_balance_pin_mv == open_wire_limit_cell_sense_pin_mv)
		else $error("open-wire limits differ");

	a_code_max_top: assert property (@(posedge pclk) disable iff (!presetn)
		cell_code == 5'h1F ##1 cell_code == 5'h1F |-> cell_delta_limit_mv == 8'h63)
		else $error("all-ones cell code not maximum");

endmodule

/* File: sim/dct_regs_tb.sv */
// Self-checking bench for the diagnostic threshold register bank
`timescale 1ns/1ps
module dct_regs_tb;
	import dct_pkg::*;
	// ****************************************************************
	// Stimulus signals, model state and counters
	// ****************************************************************
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0] pstrb = 4'h0;
	logic pready, pslverr, cell_above_busbar = 1'b0, cell_cmp_valid = 1'b0, pin_cmp_valid = 1'b0;
	logic [2:0] comp_sel = 3'h0;
	logic [15:0] main_cell_reading = 16'h0, aux_cell_reading = 16'h0, balancing_switch_on;
	logic [15:0] main_pin_reading = 16'h0, aux_pin_reading = 16'h0;
	logic cell_cmp_done, cell_cmp_pass, pin_cmp_done, pin_cmp_pass;
	logic [7:0] cell_delta_limit_mv, busbar_margin_mv;
	logic [5:0] aux_pin_delta_limit_mv;
	logic [12:0] open_wire_limit_cell_balance_pin_mv, open_wire_limit_cell_sense_pin_mv;
	int mreg[4] = '{default: 0};
	int failures = 0, cmp_count = 0, cyc = 0;
	// Clock at 125 MHz
	always #4 pclk = ~pclk;
	dct_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .comp_sel(comp_sel),
		.balancing_switch_on(balancing_switch_on), .cell_cmp_valid(cell_cmp_valid),
		.main_cell_reading(main_cell_reading), .aux_cell_reading(aux_cell_reading),
		.cell_above_busbar(cell_above_busbar), .cell_cmp_done(cell_cmp_done),
		.cell_cmp_pass(cell_cmp_pass), .pin_cmp_valid(pin_cmp_valid),
		.main_pin_reading(main_pin_reading), .aux_pin_reading(aux_pin_reading),
		.pin_cmp_done(pin_cmp_done), .pin_cmp_pass(pin_cmp_pass),
		.cell_delta_limit_mv(cell_delta_limit_mv), .busbar_margin_mv(busbar_margin_mv),
		.aux_pin_delta_limit_mv(aux_pin_delta_limit_mv),
		.open_wire_limit_cell_balance_pin_mv(open_wire_limit_cell_balance_pin_mv),
		.open_wire_limit_cell_sense_pin_mv(open_wire_limit_cell_sense_pin_mv));
	// ****************************************************************
	// Checking and bus tasks
	// ****************************************************************
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Hang guard, generous against the roughly 1500 cycles the run needs
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			wrap_up();
		end
	end
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Model index of a byte address, -1 when unmapped
	function automatic int idx(logic [11:0] a);
		int k;
		k = int'(a) - int'(DCT_ADDR_BAL_HI);
		return (k >= 0 && k < 16 && k % 4 == 0) ? k / 4 : -1;
	endfunction
	function automatic logic [11:0] ad(int i);
		return DCT_ADDR_BAL_HI + 12'(4 * i);
	endfunction
	// One APB transfer; request held until pready is sampled high at an edge
	task automatic apb(bit wr, logic [11:0] a, logic [31:0] d, logic [3:0] s,
		output logic [31:0] rd, output logic er);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		// A slave that never answers is a mismatch, not a silent pass
		if (pready !== 1'b1) begin
			failures++;
			$display("[ERR] pready expected 1 seen %b", pready);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(logic [11:0] a, logic [31:0] d, logic [3:0] s);
		logic [31:0] rd;
		logic er;
		apb(1'b1, a, d, s, rd, er);
		chk("pslverr", idx(a) < 0, er);
		// Reserved top bit of the pin/open-wire register never holds a one
		if (idx(a) >= 0 && s[0]) mreg[idx(a)] = d[7:0] & (idx(a) == 3 ? 8'h7F : 8'hFF);
	endtask
	task automatic rdc(logic [11:0] a);
		logic [31:0] rd;
		logic er;
		apb(1'b0, a, 32'h0, 4'h0, rd, er);
		chk("prdata", idx(a) < 0 ? 0 : mreg[idx(a)], rd);
		chk("pslverr", idx(a) < 0, er);
	endtask
	task automatic chk_all;
		chk("cell_lim", 6 + 3 * (mreg[2] & 31), cell_delta_limit_mv);
		chk("bb_margin", 5 + 5 * (mreg[2] >> 5), busbar_margin_mv);
		chk("pin_lim", 4 + 4 * ((mreg[3] >> 4) & 7), aux_pin_delta_limit_mv);
		chk("ow_cb", 500 + 300 * (mreg[3] & 15), open_wire_limit_cell_balance_pin_mv);
		chk("ow_cs", 500 + 300 * (mreg[3] & 15), open_wire_limit_cell_sense_pin_mv);
		chk("sw", comp_sel == 3'h4 ? (mreg[0] << 8) | mreg[1] : 0, balancing_switch_on);
	endtask
	// Deltas one below, equal to, and random around the limit; equal must fail
	task automatic cmp_run(bit pin, int lim, int marg);
		int m, d, a, l;
		bit ab;
		for (int j = 0; j < 3; j++) begin
			ab = pin ? 1'b0 : 1'($urandom_range(0, 1));
			l = lim + (ab ? marg : 0);
			d = (j == 0) ? l - 1 : (j == 1) ? l : $urandom_range(0, l + 4);
			m = $urandom_range(200, 4000);
			a = $urandom_range(0, 1) ? m + d : m - d;
			@(posedge pclk);
			pin_cmp_valid <= pin;
			cell_cmp_valid <= !pin;
			main_pin_reading <= 16'(m);
			aux_pin_reading <= 16'(a);
			main_cell_reading <= 16'(m);
			aux_cell_reading <= 16'(a);
			cell_above_busbar <= ab;
			@(posedge pclk);
			cell_cmp_valid <= 1'b0;
			pin_cmp_valid <= 1'b0;
			#1;
			chk("done", 1, pin ? pin_cmp_done : cell_cmp_done);
			chk("pass", d < l, pin ? pin_cmp_pass : cell_cmp_pass);
		end
	endtask
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		void'($urandom(32'h9B1804B4));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 4; i++) rdc(ad(i));
		chk_all();
		// Sweep every code of every threshold field, every comparator selection; enable registers get random values
		for (int k = 0; k < 32; k++) begin
			wr(ad(0), $urandom, 4'hF);
			wr(ad(1), $urandom, 4'hF);
			wr(ad(2), {24'($urandom), k[2:0], k[4:0]}, 4'hF);
			wr(ad(3), {24'($urandom), 1'($urandom), k[2:0], k[3:0]}, 4'hF);
			for (int i = 0; i < 4; i++) rdc(ad(i));
			comp_sel <= k[2:0];
			repeat (2) @(posedge pclk);
			#1;
			chk_all();
			cmp_run(1'b0, 6 + 3 * (mreg[2] & 31), 5 + 5 * (mreg[2] >> 5));
			cmp_run(1'b1, 4 + 4 * ((mreg[3] >> 4) & 7), 0);
		end
		// Lane strobe low leaves the register alone; unmapped places answer with an error
		wr(ad(0), 32'h0000_00A5, 4'hE);
		rdc(ad(0));
		wr(ad(4), 32'h0000_00FF, 4'hF);
		rdc(ad(4));
		rdc(12'h000);
		// Reset in mid-run brings every register and decode back to its start value
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		mreg = '{default: 0};
		for (int i = 0; i < 4; i++) rdc(ad(i));
		repeat (2) @(posedge pclk);
		#1;
		chk_all();
		wrap_up();
	end
endmodule
